// ---- common/fsps_pkg.sv ----
/*
 * Shared constants and carrier types for the flash self-programming sequencer.
 * Assumes an 8-bit CPU-side register write path and a flash array model outside.
 */
package fsps_pkg;
	localparam logic [7:0] CMD_NONE = 8'h00;
	localparam logic [7:0] CMD_VERIFY = 8'h02;
	localparam logic [7:0] CMD_ERASE = 8'h03;
	localparam logic [7:0] CMD_BLANK = 8'h04;
	localparam logic [7:0] UNLOCK_CODE = 8'hA5;
	localparam logic [7:0] LOW_ZERO = 8'h00;
	localparam logic [7:0] LOW_FULL = 8'hFF;
	localparam int BIT_SEQ_ERR = 0;
	localparam int BIT_VERIFY_ERR = 1;
	localparam int BIT_PROT_ERR = 2;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] CMD_RST = 8'h00;
	localparam logic MODE_RST = 1'b0;
	localparam int OP_CYCLES = 16;

	typedef enum logic [2:0] {
		FSPS_W_NONE,
		FSPS_W_CMD,
		FSPS_W_PTR_HI,
		FSPS_W_PTR_LO,
		FSPS_W_CMP_HI,
		FSPS_W_CMP_LO,
		FSPS_W_STATUS,
		FSPS_W_MODE
	} fsps_wsel_t;

	typedef struct packed {
		logic valid;
		fsps_wsel_t sel;
		logic [7:0] data;
	} fsps_wr_t;

	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} fsps_addr_t;
endpackage

// ---- design/fsps_sequencer.sv ----
/*
 * Flash self-programming command sequencer: register file, HALT-started
 * command engine, error status and the protected mode-control unlock.
 * Assumes the CPU stalls while halt_hold is high and that the flash array
 * answers each address probe in the same cycle via the flash_* inputs.
 */
// Notes on behaviour
// - Command 03H erases one whole block
// - HALT starts command, resumes after halt
// - Verify error bit1, protect error bit2
// - Erase of protected area sets bit2
// - Command 04H blank checks pointer-to-compare range
// - Status zero means normal termination
// - Command 02H verifies pointer-to-compare range
// - Unlock A5H, then three writes, last counts
// - Bad mode write ignored, sets bit0
// - Error flags stay until written zero
`timescale 1ns/10ps
module fsps_sequencer (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// CPU register writes and halt
	input wire fsps_pkg::fsps_wr_t cpu_wr,
	input wire logic halt_req,
	output logic halt_hold,
	// Register read-back
	output logic [7:0] flash_command_reg,
	output fsps_pkg::fsps_addr_t addr_ptr,
	output fsps_pkg::fsps_addr_t addr_cmp,
	output logic [7:0] flash_error_flags,
	output logic programming_mode_ctrl,
	// Flash array side
	output logic flash_erase_pulse,
	output fsps_pkg::fsps_addr_t flash_addr,
	input wire logic flash_protected,
	input wire logic flash_cell_blank,
	input wire logic flash_cell_match
);
	typedef enum logic [1:0] {FSPS_IDLE, FSPS_RUN, FSPS_SCAN, FSPS_DONE} fsps_state_t;
	typedef enum logic [1:0] {FSPS_U_IDLE, FSPS_U_ARMED, FSPS_U_SET, FSPS_U_INV} fsps_unlock_t;

	fsps_state_t state_q;
	fsps_unlock_t unlock_q;
	logic [7:0] pending_q;
	logic [4:0] timer_q;
	logic [7:0] status_d;
	logic [7:0] status_q;
	logic [7:0] cmd_q;
	fsps_pkg::fsps_addr_t ptr_q, cmp_q, scan_q;
	logic mode_q;
	logic mode_first_q;
	logic hold_q;
	logic erase_q;
	logic set_verify, set_prot, set_seq;
	logic wr_mode;

	function automatic logic wr_hit(input fsps_pkg::fsps_wr_t w, input fsps_pkg::fsps_wsel_t s);
		wr_hit = w.valid && (w.sel == s);
	endfunction

	assign wr_mode = wr_hit(cpu_wr, fsps_pkg::FSPS_W_MODE);

	// Registers loaded by firmware
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmd_q <= fsps_pkg::CMD_RST;
			ptr_q <= '0;
			cmp_q <= '0;
		end else begin
			if (wr_hit(cpu_wr, fsps_pkg::FSPS_W_CMD)) cmd_q <= cpu_wr.data;
			if (wr_hit(cpu_wr, fsps_pkg::FSPS_W_PTR_HI)) ptr_q.hi <= cpu_wr.data;
			if (wr_hit(cpu_wr, fsps_pkg::FSPS_W_PTR_LO)) ptr_q.lo <= cpu_wr.data;
			if (wr_hit(cpu_wr, fsps_pkg::FSPS_W_CMP_HI)) cmp_q.hi <= cpu_wr.data;
			if (wr_hit(cpu_wr, fsps_pkg::FSPS_W_CMP_LO)) cmp_q.lo <= cpu_wr.data;
		end
	end

	// Command engine; the CPU is held for the whole run, so no register
	// write can race the scan.
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= FSPS_IDLE;
			pending_q <= fsps_pkg::CMD_NONE;
			timer_q <= '0;
			scan_q <= '0;
			hold_q <= 1'b0;
			erase_q <= 1'b0;
		end else begin
			erase_q <= 1'b0;
			case (state_q)
				FSPS_IDLE: begin
					if (halt_req && cmd_q != fsps_pkg::CMD_NONE) begin
						state_q <= (cmd_q == fsps_pkg::CMD_ERASE) ? FSPS_RUN : FSPS_SCAN;
						pending_q <= cmd_q;
						scan_q <= ptr_q;
						timer_q <= 5'(fsps_pkg::OP_CYCLES);
						hold_q <= 1'b1;
					end
				end
				FSPS_RUN: begin
					// Whole-block erase, refused on protected blocks
					timer_q <= timer_q - 5'd1;
					if (timer_q == 5'd1) begin
						erase_q <= !flash_protected;
						state_q <= FSPS_DONE;
					end
				end
				FSPS_SCAN: begin
					// Blank check and verify walk pointer to compare address
					if (scan_q == cmp_q || set_verify) state_q <= FSPS_DONE;
					else scan_q <= {scan_q.hi, scan_q.lo} + 16'd1;
				end
				FSPS_DONE: begin
					hold_q <= 1'b0;
					state_q <= FSPS_IDLE;
				end
				default: state_q <= FSPS_IDLE;
			endcase
		end
	end

	assign set_prot = (state_q == FSPS_RUN) && timer_q == 5'd1 && flash_protected;
	assign set_verify = (state_q == FSPS_SCAN) && ((pending_q == fsps_pkg::CMD_BLANK) ? !flash_cell_blank
		: !flash_cell_match);

	// Mode-control unlock sequence
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			unlock_q <= FSPS_U_IDLE;
			mode_q <= fsps_pkg::MODE_RST;
			mode_first_q <= fsps_pkg::MODE_RST;
		end else if (wr_hit(cpu_wr, fsps_pkg::FSPS_W_NONE) && cpu_wr.data == fsps_pkg::UNLOCK_CODE) begin
			unlock_q <= FSPS_U_ARMED;
		end else if (wr_mode) begin
			case (unlock_q)
				FSPS_U_ARMED: begin
					mode_first_q <= cpu_wr.data[0];
					unlock_q <= FSPS_U_SET;
				end
				FSPS_U_SET: begin
					// Second write must carry the inverse of the first
					if (cpu_wr.data[0] == mode_first_q) unlock_q <= FSPS_U_IDLE;
					else unlock_q <= FSPS_U_INV;
				end
				FSPS_U_INV: begin
					mode_q <= cpu_wr.data[0];
					unlock_q <= FSPS_U_IDLE;
				end
				default: unlock_q <= FSPS_U_IDLE;
			endcase
		end
	end

	assign set_seq = wr_mode && (unlock_q == FSPS_U_IDLE
		|| (unlock_q == FSPS_U_SET && cpu_wr.data[0] == mode_first_q));

	// Status: hardware set beats a software clear in the same cycle
	always_comb begin
		status_d = status_q;
		if (wr_hit(cpu_wr, fsps_pkg::FSPS_W_STATUS)) status_d = cpu_wr.data & status_q;
		if (set_seq) status_d[fsps_pkg::BIT_SEQ_ERR] = 1'b1;
		if (set_verify) status_d[fsps_pkg::BIT_VERIFY_ERR] = 1'b1;
		if (set_prot) status_d[fsps_pkg::BIT_PROT_ERR] = 1'b1;
		status_d[7:3] = 5'h00;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) status_q <= fsps_pkg::STATUS_RST;
		else status_q <= status_d;
	end

	always_comb begin
		halt_hold = hold_q;
		flash_command_reg = cmd_q;
		addr_ptr = ptr_q;
		addr_cmp = cmp_q;
		flash_error_flags = status_q;
		programming_mode_ctrl = mode_q;
		flash_erase_pulse = erase_q;
		// Scan register also holds the erase block, so the probe comes from a flop
		flash_addr = scan_q;
	end

	property p_halt_idle;
		@(posedge clk) disable iff (!resetn)
		(state_q == FSPS_IDLE && halt_req && cmd_q == fsps_pkg::CMD_NONE) |=> !hold_q;
	endproperty
	a_halt_idle: assert property (p_halt_idle) else $error("plain halt started a command");

	property p_erase_len;
		@(posedge clk) disable iff (!resetn)
		(state_q == FSPS_IDLE && halt_req && cmd_q == fsps_pkg::CMD_ERASE) |=> hold_q [*8];
	endproperty
	a_erase_len: assert property (p_erase_len) else $error("erase hold too short");

	property p_prot;
		@(posedge clk) disable iff (!resetn)
		set_prot |=> status_q[fsps_pkg::BIT_PROT_ERR] && !erase_q;
	endproperty
	a_prot: assert property (p_prot) else $error("protected erase not flagged");

	property p_seq;
		@(posedge clk) disable iff (!resetn)
		set_seq |=> status_q[fsps_pkg::BIT_SEQ_ERR] && $stable(mode_q);
	endproperty
	a_seq: assert property (p_seq) else $error("bad mode write not refused");

	property p_sticky;
		@(posedge clk) disable iff (!resetn)
		(status_q[fsps_pkg::BIT_VERIFY_ERR] && !wr_hit(cpu_wr, fsps_pkg::FSPS_W_STATUS))
			|=> status_q[fsps_pkg::BIT_VERIFY_ERR];
	endproperty
	a_sticky: assert property (p_sticky) else $error("verify flag dropped");

	property p_resume;
		@(posedge clk) disable iff (!resetn)
		(state_q == FSPS_DONE) |=> !hold_q;
	endproperty
	a_resume: assert property (p_resume) else $error("halt not released");

	property p_verify_src;
		@(posedge clk) disable iff (!resetn)
		$rose(status_q[fsps_pkg::BIT_VERIFY_ERR]) |-> $past(state_q == FSPS_SCAN);
	endproperty
	a_verify_src: assert property (p_verify_src) else $error("verify flag set outside a scan");

	property p_scan_end;
		@(posedge clk) disable iff (!resetn)
		(state_q == FSPS_SCAN && scan_q == cmp_q) |=> state_q == FSPS_DONE;
	endproperty
	a_scan_end: assert property (p_scan_end) else $error("scan overran compare");

	c_erase: cover property (@(posedge clk) erase_q);
	c_blank_fail: cover property (@(posedge clk) set_verify && pending_q == fsps_pkg::CMD_BLANK);
	c_mode: cover property (@(posedge clk) wr_mode && unlock_q == FSPS_U_INV);
endmodule

// ---- bench/fsps_flash_model.sv ----
/*
 * Flash array stand-in that answers the sequencer's address probes.
 * Assumes answers are sampled in the same cycle as the probe address.
 */
`timescale 1ns/10ps
module fsps_flash_model #(
	parameter logic [15:0] BAD_ADDR = 16'h0110,
	parameter logic [7:0] PROT_BLOCK = 8'h07
) (
	// Probe
	input wire fsps_pkg::fsps_addr_t flash_addr,
	// Answers
	output logic flash_protected,
	output logic flash_cell_blank,
	output logic flash_cell_match
);
	assign flash_protected = flash_addr.hi == PROT_BLOCK;
	// One bad cell serves both scans
	assign flash_cell_blank = flash_addr != BAD_ADDR;
	assign flash_cell_match = flash_addr != BAD_ADDR;
endmodule

// ---- bench/tb_fsps_sequencer.sv ----
/*
 * Self-checking bench for the sequencer: firmware-style command runs.
 * Assumes the flash model's bad cell at 0110H and protected block 07H.
 */
`timescale 1ns/10ps
module tb_fsps_sequencer;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	fsps_pkg::fsps_wr_t cpu_wr = '0;
	logic halt_req = 1'b0;
	logic halt_hold, programming_mode_ctrl, flash_erase_pulse, flash_protected, flash_cell_blank, flash_cell_match;
	logic [7:0] flash_command_reg, flash_error_flags;
	fsps_pkg::fsps_addr_t addr_ptr, addr_cmp, flash_addr;
	int miscompares = 0;
	int tests_run = 0;
	int cycles = 0;
	int pulses = 0;
	int n;
	int wdt_count = 0;
	logic [7:0] watchdog_restart_reg = 8'h00;
	logic [7:0] erase_blk = 8'h00;

	fsps_sequencer u_fsps_sequencer (.clk(clk), .resetn(resetn), .cpu_wr(cpu_wr), .halt_req(halt_req),
		.halt_hold(halt_hold), .flash_command_reg(flash_command_reg), .addr_ptr(addr_ptr),
		.addr_cmp(addr_cmp), .flash_error_flags(flash_error_flags),
		.programming_mode_ctrl(programming_mode_ctrl), .flash_erase_pulse(flash_erase_pulse),
		.flash_addr(flash_addr), .flash_protected(flash_protected), .flash_cell_blank(flash_cell_blank),
		.flash_cell_match(flash_cell_match));
	fsps_flash_model u_fsps_flash_model (.flash_addr(flash_addr), .flash_protected(flash_protected),
		.flash_cell_blank(flash_cell_blank), .flash_cell_match(flash_cell_match));

	initial begin
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (flash_erase_pulse === 1'b1) begin
			pulses++;
			erase_blk = flash_addr.hi;
		end
		// Watchdog stand-in: restarted by the ACH code, else counts up
		if (watchdog_restart_reg == 8'hAC) wdt_count = 0;
		else wdt_count++;
		// Longest run is one full-block scan
		if (cycles == 5000) begin
			miscompares++;
			final_report();
		end
	end

	task automatic final_report();
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input fsps_pkg::fsps_wsel_t s, input logic [7:0] d);
		@(posedge clk);
		#10;
		cpu_wr = '{1'b1, s, d};
		@(posedge clk);
		#10;
		cpu_wr.valid = 1'b0;
	endtask

	// Firmware sequence: load registers, clear status, halt, wait
	task automatic run(input logic [7:0] c, input logic [15:0] p, input logic [15:0] e);
		wr(fsps_pkg::FSPS_W_CMD, c);
		wr(fsps_pkg::FSPS_W_PTR_HI, p[15:8]);
		wr(fsps_pkg::FSPS_W_PTR_LO, p[7:0]);
		wr(fsps_pkg::FSPS_W_CMP_HI, e[15:8]);
		wr(fsps_pkg::FSPS_W_CMP_LO, e[7:0]);
		wr(fsps_pkg::FSPS_W_STATUS, 8'h00);
		@(posedge clk);
		#10;
		watchdog_restart_reg = 8'hAC;
		@(posedge clk);
		#10;
		watchdog_restart_reg = 8'h00;
		halt_req = 1'b1;
		@(posedge clk);
		#10;
		halt_req = 1'b0;
		n = 0;
		while (halt_hold === 1'b1 && n < 400) begin
			@(posedge clk);
			#10;
			n++;
		end
		chk("command", c, flash_command_reg);
		chk("ptr_hi", p[15:8], addr_ptr.hi);
		chk("ptr_lo", p[7:0], addr_ptr.lo);
		chk("cmp_hi", e[15:8], addr_cmp.hi);
		chk("cmp_lo", e[7:0], addr_cmp.lo);
		chk("watchdog", 8'h01, {7'h00, wdt_count < 300});
	endtask

	initial begin
		repeat (4) @(posedge clk);
		#10;
		resetn = 1'b1;
		chk("flags", fsps_pkg::STATUS_RST, flash_error_flags);
		run(fsps_pkg::CMD_ERASE, 16'h0300, 16'h0300);
		chk("hold", 8'(fsps_pkg::OP_CYCLES + 1), 8'(n));
		chk("pulses", 8'h01, 8'(pulses));
		chk("erase_block", 8'h03, erase_blk);
		chk("flags", 8'h00, flash_error_flags);
		// Firmware retries a failed erase a bounded number of times
		repeat (2) begin
			run(fsps_pkg::CMD_ERASE, 16'h0700, 16'h0700);
			chk("flags", 8'h04, flash_error_flags);
		end
		chk("pulses", 8'h01, 8'(pulses));
		chk("erase_block", 8'h03, erase_blk);
		wr(fsps_pkg::FSPS_W_STATUS, 8'hFF);
		chk("flags", 8'h04, flash_error_flags);
		wr(fsps_pkg::FSPS_W_STATUS, 8'h00);
		chk("flags", 8'h00, flash_error_flags);
		$display("erase done");
		run(fsps_pkg::CMD_BLANK, 16'h0100, 16'h01FF);
		chk("flags", 8'h02, flash_error_flags);
		run(fsps_pkg::CMD_BLANK, 16'h0200, 16'h02FF);
		chk("flags", 8'h00, flash_error_flags);
		$display("blank check done");
		run(fsps_pkg::CMD_VERIFY, 16'h0100, 16'h0110);
		chk("flags", 8'h02, flash_error_flags);
		run(fsps_pkg::CMD_VERIFY, 16'h0111, 16'h0130);
		chk("flags", 8'h00, flash_error_flags);
		$display("verify done");
		run(fsps_pkg::CMD_NONE, 16'h0300, 16'h0300);
		chk("hold", 8'h00, 8'(n));
		$display("plain halt done");
		wr(fsps_pkg::FSPS_W_MODE, 8'h01);
		chk("flags", 8'h01, flash_error_flags);
		chk("mode", 8'h00, {7'h00, programming_mode_ctrl});
		wr(fsps_pkg::FSPS_W_STATUS, 8'h00);
		wr(fsps_pkg::FSPS_W_NONE, fsps_pkg::UNLOCK_CODE);
		wr(fsps_pkg::FSPS_W_MODE, 8'h01);
		wr(fsps_pkg::FSPS_W_MODE, 8'hFE);
		chk("mode", 8'h00, {7'h00, programming_mode_ctrl});
		wr(fsps_pkg::FSPS_W_MODE, 8'h01);
		chk("mode", 8'h01, {7'h00, programming_mode_ctrl});
		chk("flags", 8'h00, flash_error_flags);
		wr(fsps_pkg::FSPS_W_NONE, fsps_pkg::UNLOCK_CODE);
		wr(fsps_pkg::FSPS_W_MODE, 8'h00);
		wr(fsps_pkg::FSPS_W_MODE, 8'h00);
		chk("flags", 8'h01, flash_error_flags);
		chk("mode", 8'h01, {7'h00, programming_mode_ctrl});
		wr(fsps_pkg::FSPS_W_STATUS, 8'h00);
		wr(fsps_pkg::FSPS_W_NONE, fsps_pkg::UNLOCK_CODE);
		wr(fsps_pkg::FSPS_W_MODE, 8'h00);
		wr(fsps_pkg::FSPS_W_MODE, 8'hFF);
		wr(fsps_pkg::FSPS_W_MODE, 8'h00);
		chk("mode", 8'h00, {7'h00, programming_mode_ctrl});
		chk("flags", 8'h00, flash_error_flags);
		$display("mode unlock done");
		final_report();
	end
endmodule
